/* dic_core_ctl.sv */
// issue, execution pipeline, register file and timer control of the core
//
// Overview of operation
// - issue up to two instructions per cycle
// - three front stages, four-stage execution pipes
// - register file 32x32, six reads, three writes
// - two file copies: complex alone, others shared
// - complex pipe runs alu, branch, system, mul, div
// - full multiply pipelined, result after three cycles
// - half multiply result after two cycles
// - divide holds complex pipe 33 cycles
// - simple pipe only for flag-preserving ops
// - misaligned in hardware, split across 16-byte
// - big or little endian per page
// - trap 64-bit and unattached floating-point ops
// - architected bit 0 is most significant
// - history table and target cache predict branches
// - three 128-bit bus ports, ratios supported
// - caches 32 KB, 32-byte lines, 64-way, parity
// - at most four outstanding load misses
// - 64-entry translation buffer, 36-bit real address
// - coprocessor port has 128-bit cache path
// - time base, decrementer, interval timer, watchdog
`timescale 1ns/100ps
module dic_core_ctl
    import dic_pkg::*;
#(
    parameter int BHT_N = 64,
    parameter int BRANCH_TARGET_CACHE_N = 16,
    parameter int FIT_BIT = 17,
    parameter int WD_BIT = 21
)(
    input wire logic clk_sys_i, // core clock
    input wire logic rst_i, // async reset, high
    input wire logic [1:0] slot_valid_i, // bit 0 older slot
    input wire dic_cls_t slot_cls_i [2], // decoded class per slot
    input wire logic [1:0] slot_flags_i, // op updates flags
    input wire logic [XLEN-1:0] slot_a_i [2], // operand a per slot
    input wire logic [XLEN-1:0] slot_b_i [2], // operand b per slot
    input wire logic [3:0] pipe_rdy_i, // cplx, simp, ldst, cop
    input wire logic fpu_present_i, // float unit on coprocessor
    output logic [1:0] take_o, // slot consumed this cycle
    output logic [3:0] issue_o, // issued per pipe
    output logic [2:0] exe_done_o, // leaving last stage
    output logic trap_o, // unsupported op trapped
    output logic mul_valid_o, // multiply result valid
    output logic [XLEN-1:0] mul_res_o, // multiply result
    output logic div_busy_o, // divider occupies pipe
    output logic div_valid_o, // quotient valid
    output logic [XLEN-1:0] div_res_o, // quotient
    input wire logic [4:0] rd_addr_i [RD_PORTS], // read addresses
    output logic [XLEN-1:0] rd_data_o [RD_PORTS], // read data
    input wire logic [WR_PORTS-1:0] wr_en_i, // write enables
    input wire logic [4:0] wr_addr_i [WR_PORTS], // write addresses
    input wire logic [XLEN-1:0] wr_data_i [WR_PORTS], // write data
    input wire logic ls_req_i, // load/store access
    input wire logic [3:0] ls_off_i, // address low bits
    input wire logic [4:0] ls_size_i, // bytes, 1 to 16
    input wire logic ls_big_i, // page is big endian
    input wire logic [XLEN-1:0] ls_wdata_i, // store word
    output logic ls_split_o, // needs two accesses
    output logic [XLEN-1:0] ls_data_o, // lane-ordered store
    input wire logic ld_miss_i, // load missed cache
    input wire logic ld_fill_i, // miss returned
    output logic miss_full_o, // no more misses allowed
    input wire logic [XLEN-1:0] fetch_pc_i, // fetch address
    output logic pred_taken_o, // predicted taken
    output logic [XLEN-1:0] pred_tgt_o, // predicted target
    input wire logic br_upd_i, // resolved branch
    input wire logic [XLEN-1:0] br_pc_i, // resolved address
    input wire logic br_taken_i, // resolved direction
    input wire logic [XLEN-1:0] br_tgt_i, // resolved target
    input wire logic dec_load_i, // write decrementer
    input wire logic [XLEN-1:0] dec_val_i, // decrementer value
    input wire logic dec_auto_i, // auto reload enable
    input wire logic wd_irq_en_i, // watchdog interrupt enable
    input wire logic wd_rst_en_i, // watchdog reset enable
    input wire logic wd_kick_i, // watchdog service
    output logic [TB_BITS-1:0] tb_o, // time base
    output logic dec_event_o, // decrementer hit zero
    output logic fit_event_o, // interval tick
    output logic wd_irq_o, // watchdog critical irq
    output logic wd_rst_o // watchdog reset request
);
    localparam int BI = $clog2(BHT_N);
    localparam int TI = $clog2(BRANCH_TARGET_CACHE_N);

    // -------------------------------------------------
    // elaboration checks
    // -------------------------------------------------
    if (BHT_N < 2 || (BHT_N & (BHT_N - 1)) != 0 || BRANCH_TARGET_CACHE_N < 2 ||
        (BRANCH_TARGET_CACHE_N & (BRANCH_TARGET_CACHE_N - 1)) != 0 || FIT_BIT >= TB_BITS || WD_BIT >= TB_BITS ||
        BI + 2 > XLEN || TI + 2 > XLEN)
        $error("dic_core_ctl: unsupported parameter values");
    // structure seen by the bus, cache and translation logic outside
    if (BUS_BITS != 128 || CACHE_KB * 1024 != CACHE_WAYS * LINE_BYTES * 16 ||
        TLB_ENTRIES != 64 || REAL_ABITS != 36)
        $error("dic_core_ctl: memory system constants inconsistent");

    // architected bit n is hardware bit XLEN-1-n
    function automatic int arch_bit(input int n);
        return XLEN - 1 - n;
    endfunction

    // -------------------------------------------------
    // issue steering
    // -------------------------------------------------
    dic_pipe_t pipe_s [2];
    logic [1:0] ok_s;
    logic div_busy_q, mul32_q, cx_slot;
    logic [3:0] iss_d;
    logic trap_d;

    for (genvar s = 0; s < 2; s++)
    begin : g_slot
        always_comb
        begin
            unique case (slot_cls_i[s])
                CL_INT: pipe_s[s] = slot_flags_i[s] ? PP_CPLX : PP_SIMP;
                CL_LDST: pipe_s[s] = PP_LDST;
                CL_COP: pipe_s[s] = PP_COP;
                CL_OP64: pipe_s[s] = PP_TRAP;
                CL_FP: pipe_s[s] = fpu_present_i ? PP_COP : PP_TRAP;
                default: pipe_s[s] = PP_CPLX;
            endcase
            // the divider owns the complex pipe; a half multiply right after a
            // full one would land on the same result cycle
            unique case (pipe_s[s])
                PP_CPLX: ok_s[s] = pipe_rdy_i[0] && !div_busy_q &&
                    !(slot_cls_i[s] == CL_MUL16 && mul32_q);
                PP_SIMP: ok_s[s] = pipe_rdy_i[1];
                PP_LDST: ok_s[s] = pipe_rdy_i[2];
                PP_COP: ok_s[s] = pipe_rdy_i[3];
                default: ok_s[s] = 1'b1;
            endcase
        end
    end

    always_comb
    begin
        take_o[0] = slot_valid_i[0] && ok_s[0];
        // younger waits when the older one stalls or wants the same pipe
        take_o[1] = take_o[0] && slot_valid_i[1] && ok_s[1] &&
            (pipe_s[1] != pipe_s[0] || pipe_s[1] == PP_TRAP);
        iss_d = 4'h0;
        trap_d = 1'b0;
        cx_slot = 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            if (take_o[s])
            begin
                if (pipe_s[s] == PP_TRAP)
                    trap_d = 1'b1;
                else
                    iss_d[pipe_s[s][1:0]] = 1'b1;
                if (pipe_s[s] == PP_CPLX)
                    cx_slot = s[0];
            end
        end
    end

    // -------------------------------------------------
    // execution stages
    // -------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            issue_o <= 4'h0;
            trap_o <= 1'b0;
        end
        else
        begin
            issue_o <= iss_d;
            trap_o <= trap_d;
        end
    end

    for (genvar p = 0; p < 3; p++)
    begin : g_pipe
        logic [EXE_STAGES-1:0] stg_q;
        always_ff @(posedge clk_sys_i or posedge rst_i)
        begin
            if (rst_i)
                stg_q <= '0;
            else
                stg_q <= {stg_q[EXE_STAGES-2:0], iss_d[p]};
        end
        assign exe_done_o[p] = stg_q[EXE_STAGES-1];
    end

    // -------------------------------------------------
    // multiplier
    // -------------------------------------------------
    logic [XLEN-1:0] cx_a, cx_b, p1_q, p2_q;
    logic m16_go, m32_go, m16_q, m32b_q;
    assign cx_a = slot_a_i[cx_slot];
    assign cx_b = slot_b_i[cx_slot];
    assign m32_go = take_o[cx_slot] && slot_cls_i[cx_slot] == CL_MUL32 && iss_d[0];
    assign m16_go = take_o[cx_slot] && slot_cls_i[cx_slot] == CL_MUL16 && iss_d[0];

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            p1_q <= '0;
            p2_q <= '0;
            mul32_q <= 1'b0;
            m32b_q <= 1'b0;
            m16_q <= 1'b0;
            mul_valid_o <= 1'b0;
            mul_res_o <= '0;
        end
        else
        begin
            // a new operation may enter every cycle, except a half multiply right after a full one
            p1_q <= m16_go ? XLEN'({16'h0, cx_a[HALF_BITS-1:0]} * cx_b) : XLEN'(cx_a * cx_b);
            p2_q <= p1_q;
            mul32_q <= m32_go;
            m32b_q <= mul32_q;
            m16_q <= m16_go;
            mul_valid_o <= m32b_q || m16_q;
            mul_res_o <= m16_q ? p1_q : p2_q;
        end
    end

    // -------------------------------------------------
    // divider, one quotient bit per cycle
    // -------------------------------------------------
    logic [5:0] div_cnt_q;
    logic [XLEN-1:0] rem_q, quo_q, dvs_q;
    logic [XLEN:0] trial;
    logic div_go;
    assign div_go = take_o[cx_slot] && slot_cls_i[cx_slot] == CL_DIV && iss_d[0];
    assign trial = {rem_q, quo_q[XLEN-1]} - {1'b0, dvs_q};
    assign div_busy_o = div_busy_q;
    assign div_busy_q = div_cnt_q != 6'h00;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_cnt_q <= 6'h00;
            rem_q <= '0;
            quo_q <= '0;
            dvs_q <= '0;
            div_valid_o <= 1'b0;
            div_res_o <= '0;
        end
        else
        begin
            div_valid_o <= 1'b0;
            if (div_go)
            begin
                div_cnt_q <= 6'(DIV_CYC);
                rem_q <= '0;
                quo_q <= cx_a;
                dvs_q <= cx_b;
            end
            else if (div_cnt_q == 6'h01)
                div_cnt_q <= 6'h00;
            else if (div_busy_q)
            begin
                div_cnt_q <= div_cnt_q - 6'h01;
                rem_q <= trial[XLEN] ? {rem_q[XLEN-2:0], quo_q[XLEN-1]} : trial[XLEN-1:0];
                quo_q <= {quo_q[XLEN-2:0], ~trial[XLEN]};
                // last step hands the quotient out directly, saving a cycle
                if (div_cnt_q == 6'h02)
                begin
                    div_valid_o <= 1'b1;
                    div_res_o <= {quo_q[XLEN-2:0], ~trial[XLEN]};
                end
            end
        end
    end

    // -------------------------------------------------
    // register file, two copies
    // -------------------------------------------------
    // copy 0 feeds the complex pipe (ports 0-1), copy 1 the others (2-5)
    logic [XLEN-1:0] rf_q [2][NREG];
    for (genvar c = 0; c < 2; c++)
    begin : g_copy
        always_ff @(posedge clk_sys_i or posedge rst_i)
        begin
            if (rst_i)
                rf_q[c] <= '{default: '0};
            else
                for (int w = 0; w < WR_PORTS; w++)
                    if (wr_en_i[w])
                        rf_q[c][wr_addr_i[w]] <= wr_data_i[w];
        end
    end
    for (genvar r = 0; r < RD_PORTS; r++)
    begin : g_rd
        always_ff @(posedge clk_sys_i or posedge rst_i)
        begin
            if (rst_i)
                rd_data_o[r] <= '0;
            else
                rd_data_o[r] <= rf_q[r < 2 ? 0 : 1][rd_addr_i[r]];
        end
    end

    // -------------------------------------------------
    // load/store alignment and byte order
    // -------------------------------------------------
    logic [XLEN-1:0] swap;
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
        assign swap[8*b +: 8] = ls_wdata_i[8*(3-b) +: 8];
    end
    logic [2:0] miss_q;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ls_split_o <= 1'b0;
            ls_data_o <= '0;
            miss_q <= 3'h0;
        end
        else
        begin
            // inside one aligned quadword costs nothing extra
            ls_split_o <= ls_req_i && (5'(ls_off_i) + ls_size_i > 5'(QUAD_BYTES));
            if (ls_req_i)
                ls_data_o <= ls_big_i ? swap : ls_wdata_i;
            if ((ld_miss_i && !miss_full_o) && !ld_fill_i)
                miss_q <= miss_q + 3'h1;
            else if (!(ld_miss_i && !miss_full_o) && ld_fill_i && miss_q != 3'h0)
                miss_q <= miss_q - 3'h1;
        end
    end
    assign miss_full_o = miss_q == 3'(MAX_MISS);

    // -------------------------------------------------
    // branch prediction
    // -------------------------------------------------
    logic [1:0] bht_q [BHT_N];
    logic [TI-1:0] ti_f, ti_u;
    logic [BI-1:0] bi_f, bi_u;
    logic btv_q [BRANCH_TARGET_CACHE_N];
    logic [XLEN-1:0] btag_q [BRANCH_TARGET_CACHE_N];
    logic [XLEN-1:0] btgt_q [BRANCH_TARGET_CACHE_N];
    assign bi_f = fetch_pc_i[BI+1:2];
    assign bi_u = br_pc_i[BI+1:2];
    assign ti_f = fetch_pc_i[TI+1:2];
    assign ti_u = br_pc_i[TI+1:2];

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bht_q <= '{default: BHT_INIT};
            btv_q <= '{default: 1'b0};
            btag_q <= '{default: '0};
            btgt_q <= '{default: '0};
            pred_taken_o <= 1'b0;
            pred_tgt_o <= '0;
        end
        else
        begin
            if (br_upd_i)
            begin
                if (br_taken_i && bht_q[bi_u] != 2'h3)
                    bht_q[bi_u] <= bht_q[bi_u] + 2'h1;
                else if (!br_taken_i && bht_q[bi_u] != 2'h0)
                    bht_q[bi_u] <= bht_q[bi_u] - 2'h1;
                if (br_taken_i)
                begin
                    btv_q[ti_u] <= 1'b1;
                    btag_q[ti_u] <= br_pc_i;
                    btgt_q[ti_u] <= br_tgt_i;
                end
            end
            // a hit steers the very next fetch, so a taken branch costs no slot
            pred_taken_o <= bht_q[bi_f][1] && btv_q[ti_f] && btag_q[ti_f] == fetch_pc_i;
            pred_tgt_o <= btgt_q[ti_f];
        end
    end

    // -------------------------------------------------
    // timers
    // -------------------------------------------------
    logic [XLEN-1:0] dec_q, dec_rl_q;
    logic fit_tap_q, wd_tap_q;
    dic_wd_t wd_q;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tb_o <= '0;
            dec_q <= '0;
            dec_rl_q <= '0;
            dec_event_o <= 1'b0;
            fit_tap_q <= 1'b0;
            wd_tap_q <= 1'b0;
            fit_event_o <= 1'b0;
        end
        else
        begin
            tb_o <= tb_o + TB_BITS'(1);
            dec_event_o <= 1'b0;
            if (dec_load_i)
            begin
                dec_q <= dec_val_i;
                dec_rl_q <= dec_val_i;
            end
            else if (dec_q == XLEN'(1))
            begin
                dec_event_o <= 1'b1;
                dec_q <= dec_auto_i ? dec_rl_q : '0;
            end
            else if (dec_q != '0)
                dec_q <= dec_q - XLEN'(1);
            // taps named in architected numbering of the low time base word
            fit_tap_q <= tb_o[arch_bit(XLEN - 1 - FIT_BIT)];
            wd_tap_q <= tb_o[arch_bit(XLEN - 1 - WD_BIT)];
            fit_event_o <= tb_o[arch_bit(XLEN - 1 - FIT_BIT)] && !fit_tap_q;
        end
    end

    logic wd_tick;
    assign wd_tick = tb_o[WD_BIT] && !wd_tap_q;

    // first expiry arms, second raises the irq, third asks for reset
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wd_q <= WD_IDLE;
            wd_irq_o <= 1'b0;
            wd_rst_o <= 1'b0;
        end
        else if (wd_kick_i)
        begin
            wd_q <= WD_IDLE;
            wd_irq_o <= 1'b0;
        end
        else if (wd_tick)
        begin
            unique case (wd_q)
                WD_IDLE: wd_q <= WD_ARMED;
                WD_ARMED:
                begin
                    wd_q <= WD_IRQ;
                    wd_irq_o <= wd_irq_en_i;
                end
                WD_IRQ: wd_rst_o <= wd_rst_en_i;
                default: wd_q <= WD_IDLE;
            endcase
        end
    end

    // -------------------------------------------------
    // assertions
    // -------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_div_start;
        div_go;
    endsequence
    sequence s_div_hold;
        div_busy_o [*8];
    endsequence

    a_div_occupancy: assert property (s_div_start |=> s_div_hold)
        else $error("divider released the pipe early");
    a_div_latency: assert property (s_div_start |-> ##33 div_valid_o)
        else $error("quotient not ready after 33 cycles");
    a_mul32_latency: assert property (m32_go |-> ##3 mul_valid_o)
        else $error("full multiply latency wrong");
    a_mul16_latency: assert property (m16_go |-> ##2 mul_valid_o)
        else $error("half multiply latency wrong");
    a_pair_pipes: assert property (take_o[1] |-> take_o[0] &&
        (pipe_s[0] != pipe_s[1] || pipe_s[1] == PP_TRAP))
        else $error("two instructions sent to one pipe");
    a_younger_held: assert property (&slot_valid_i && pipe_s[0] == pipe_s[1] &&
        pipe_s[0] != PP_TRAP |-> !take_o[1])
        else $error("younger instruction not held");
    a_trap_op64: assert property (take_o[0] && slot_cls_i[0] == CL_OP64 |=> trap_o)
        else $error("64-bit op not trapped");
    a_exec_depth: assert property (iss_d[1] |-> ##4 exe_done_o[1])
        else $error("simple pipe depth wrong");
    a_quad_split: assert property (ls_req_i && ls_off_i == 4'hF && ls_size_i == 5'h02
        |=> ls_split_o)
        else $error("quadword crossing not split");
    a_miss_limit: assert property (miss_full_o && !ld_fill_i |=> miss_full_o)
        else $error("too many outstanding misses");
endmodule // dic_core_ctl

/* dic_pkg.sv */
// shared constants and types for the dual-issue core pipeline control
package dic_pkg;
    localparam int XLEN = 32;
    localparam int NREG = 32;
    localparam int RD_PORTS = 6;
    localparam int WR_PORTS = 3;
    localparam int FE_STAGES = 3;
    localparam int EXE_STAGES = 4;
    localparam int MUL32_LAT = 3;
    localparam int MUL16_LAT = 2;
    localparam int DIV_CYC = 33;
    localparam int QUAD_BYTES = 16;
    localparam int MAX_MISS = 4;
    localparam int BUS_BITS = 128;
    localparam int CACHE_KB = 32;
    localparam int LINE_BYTES = 32;
    localparam int CACHE_WAYS = 64;
    localparam int TLB_ENTRIES = 64;
    localparam int REAL_ABITS = 36;
    localparam int TB_BITS = 64;
    localparam int HALF_BITS = 16;
    localparam logic [1:0] BHT_INIT = 2'h1;

    typedef enum logic [3:0] {
        CL_INT = 4'h0, CL_BR = 4'h1, CL_SYS = 4'h2, CL_LDST = 4'h3,
        CL_COP = 4'h4, CL_MUL32 = 4'h5, CL_MUL16 = 4'h6, CL_DIV = 4'h7,
        CL_MAC = 4'h8, CL_OP64 = 4'h9, CL_FP = 4'hA
    } dic_cls_t;

    typedef enum logic [2:0] {
        PP_CPLX = 3'h0, PP_SIMP = 3'h1, PP_LDST = 3'h2, PP_COP = 3'h3, PP_TRAP = 3'h4
    } dic_pipe_t;

    typedef enum logic [1:0] {
        WD_IDLE = 2'h0, WD_ARMED = 2'h1, WD_IRQ = 2'h2
    } dic_wd_t;
endpackage

/* dic_far_end.sv */
// far-side model: pipe readiness and load miss returns
`timescale 1ns/100ps
module dic_far_end (
    input wire logic clk_sys_i, // core clock
    input wire logic rst_i, // async reset, high
    input wire logic [3:0] hold_i, // stall per pipe
    input wire logic fill_req_i, // return one miss
    output logic [3:0] pipe_rdy_o, // ready per pipe
    output logic ld_fill_o // miss returned
);
    // readiness lags a stall by one edge, as a real crossbar would
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pipe_rdy_o <= 4'h0;
            ld_fill_o <= 1'b0;
        end
        else
        begin
            pipe_rdy_o <= ~hold_i;
            ld_fill_o <= fill_req_i;
        end
    end
endmodule // dic_far_end

/* dual_issue_integer_core_pipeline_tb_top.sv */
// self-checking bench for the dual-issue core pipeline control
`timescale 1ns/100ps
module dual_issue_integer_core_pipeline_tb_top;
    import dic_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] sv = 2'h0, sf = 2'h0, take;
    dic_cls_t sc [2];
    logic [31:0] sa [2], sb [2], wdat [3], rdat [6], mres, dres, lsd, ptgt;
    logic [3:0] rdy, iss, loff = 4'h0, hold = 4'h0;
    logic [2:0] done, wen = 3'h0;
    logic [4:0] radr [6], wadr [3], lsz = 5'h1;
    logic fpu = 1'b0, lreq = 1'b0, lbig = 1'b0, miss = 1'b0, freq = 1'b0;
    logic fill, trap, mv, dbusy, dv, split, full, ptk, bu = 1'b0, bt = 1'b0;
    logic [31:0] lw = 32'h0, fpc = 32'h0, bpc = 32'h0, btg = 32'h0, dval = 32'h0;
    logic dld = 1'b0, dauto = 1'b0, wie = 1'b0, wk = 1'b0, dev, fev, wirq;
    logic [63:0] tbv;
    int err_total = 0;
    int compares = 0;

    dic_core_ctl #(.FIT_BIT(3), .WD_BIT(4)) DUT (
        .clk_sys_i(clk), .rst_i(rst), .slot_valid_i(sv), .slot_cls_i(sc),
        .slot_flags_i(sf), .slot_a_i(sa), .slot_b_i(sb), .pipe_rdy_i(rdy),
        .fpu_present_i(fpu), .take_o(take), .issue_o(iss), .exe_done_o(done),
        .trap_o(trap), .mul_valid_o(mv), .mul_res_o(mres), .div_busy_o(dbusy),
        .div_valid_o(dv), .div_res_o(dres), .rd_addr_i(radr), .rd_data_o(rdat),
        .wr_en_i(wen), .wr_addr_i(wadr), .wr_data_i(wdat), .ls_req_i(lreq),
        .ls_off_i(loff), .ls_size_i(lsz), .ls_big_i(lbig), .ls_wdata_i(lw),
        .ls_split_o(split), .ls_data_o(lsd), .ld_miss_i(miss), .ld_fill_i(fill),
        .miss_full_o(full), .fetch_pc_i(fpc), .pred_taken_o(ptk),
        .pred_tgt_o(ptgt), .br_upd_i(bu), .br_pc_i(bpc), .br_taken_i(bt),
        .br_tgt_i(btg), .dec_load_i(dld), .dec_val_i(dval), .dec_auto_i(dauto),
        .wd_irq_en_i(wie), .wd_rst_en_i(1'b0), .wd_kick_i(wk), .tb_o(tbv),
        .dec_event_o(dev), .fit_event_o(fev), .wd_irq_o(wirq), .wd_rst_o()
    );
    dic_far_end far (.clk_sys_i(clk), .rst_i(rst), .hold_i(hold),
        .fill_req_i(freq), .pipe_rdy_o(rdy), .ld_fill_o(fill));

    initial
        forever #10 clk = ~clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic finish_test;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic edg(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic go(input dic_cls_t c0, c1, input logic [1:0] v, f,
        input logic [31:0] a = 32'h0, b = 32'h0);
        @(posedge clk);
        sc[0] <= c0;
        sc[1] <= c1;
        sv <= v;
        sf <= f;
        sa[0] <= a;
        sb[0] <= b;
        #5;
    endtask

    task automatic stop;
        @(posedge clk);
        sv <= 2'h0;
        #5;
    endtask

    task automatic ls(input logic [3:0] o, input logic [4:0] s, input logic b, es,
        input logic [31:0] ed);
        @(posedge clk);
        lreq <= 1'b1;
        loff <= o;
        lsz <= s;
        lbig <= b;
        lw <= 32'h1122_3344;
        @(posedge clk);
        lreq <= 1'b0;
        #5;
        chk({split, lsd}, {es, ed}, "lanes");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_issue;
        go(CL_INT, CL_INT, 2'h1, 2'h0);
        chk(take, 2'h1, "take");
        stop();
        chk(iss, 4'h2, "issue");
        edg(3);
        chk(done, 3'h2, "done");
        @(posedge clk);
        hold <= 4'h2;
        go(CL_INT, CL_INT, 2'h1, 2'h0);
        chk(take, 2'h0, "stall");
        @(posedge clk);
        sv <= 2'h0;
        hold <= 4'h0;
        go(CL_INT, CL_INT, 2'h3, 2'h0);
        chk(take, 2'h1, "same pipe");
        go(CL_INT, CL_LDST, 2'h3, 2'h0);
        chk(take, 2'h3, "pair");
        go(CL_INT, CL_INT, 2'h3, 2'h1);
        chk({take, iss}, 6'h36, "flags");
        stop();
        chk(iss, 4'h3, "cplx simp");
    endtask

    task automatic t_arith;
        go(CL_MUL32, CL_INT, 2'h1, 2'h0, 32'h0001_2345, 32'h0000_0103);
        stop();
        edg(1);
        chk(mv, 1'b0, "mul early");
        edg(1);
        chk({mv, mres}, {1'b1, 32'h0001_2345 * 32'h0000_0103}, "mul32");
        go(CL_MUL16, CL_INT, 2'h1, 2'h0, 32'hFFFF_0010, 32'h0000_0021);
        stop();
        edg(1);
        chk({mv, mres}, {1'b1, 32'h0000_0210}, "mul16");
        go(CL_DIV, CL_INT, 2'h1, 2'h0, 32'h0000_0064, 32'h0000_0007);
        stop();
        go(CL_INT, CL_INT, 2'h1, 2'h1);
        chk({take, dbusy}, 3'h1, "div hold");
        stop();
        edg(29);
        chk({dv, dbusy}, 2'h1, "div early");
        edg(1);
        chk({dv, dres}, {1'b1, 32'h0000_000E}, "div");
    endtask

    task automatic t_misc;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            fpu <= i[0];
            go(CL_FP, CL_INT, 2'h1, 2'h0);
            stop();
            chk({trap, iss}, {~i[0], i[0], 3'h0}, "fp");
        end
        go(CL_OP64, CL_INT, 2'h1, 2'h0);
        stop();
        chk(trap, 1'b1, "op64");
        @(posedge clk);
        wen <= 3'h7;
        for (int i = 0; i < 3; i++)
        begin
            wadr[i] <= 5'(5 + i);
            wdat[i] <= 32'hA500_0000 + 32'(i);
        end
        @(posedge clk);
        wen <= 3'h0;
        for (int i = 0; i < 6; i++)
            radr[i] <= 5'(5 + i % 3);
        edg(2);
        for (int i = 0; i < 6; i++)
            chk(rdat[i], 32'hA500_0000 + 32'(i % 3), "reg");
        ls(4'hF, 5'h02, 1'b0, 1'b1, 32'h1122_3344);
        ls(4'hC, 5'h04, 1'b1, 1'b0, 32'h4433_2211);
        ls(4'h0, 5'h10, 1'b0, 1'b0, 32'h1122_3344);
    endtask

    task automatic t_miss_pred;
        @(posedge clk);
        miss <= 1'b1;
        edg(3);
        chk(full, 1'b0, "3 miss");
        @(posedge clk);
        miss <= 1'b0;
        #5;
        chk(full, 1'b1, "4 miss");
        @(posedge clk);
        freq <= 1'b1;
        @(posedge clk);
        freq <= 1'b0;
        edg(1);
        chk(full, 1'b0, "fill");
        @(posedge clk);
        bu <= 1'b1;
        bt <= 1'b1;
        bpc <= 32'h0000_1040;
        btg <= 32'h0000_2000;
        @(posedge clk);
        bu <= 1'b0;
        fpc <= 32'h0000_1040;
        edg(2);
        chk({ptk, ptgt}, {1'b1, 32'h0000_2000}, "predict");
    endtask

    task automatic t_timer;
        logic [63:0] t0;
        int n = 0;
        @(posedge clk);
        dld <= 1'b1;
        dauto <= 1'b1;
        dval <= 32'h0000_0003;
        @(posedge clk);
        dld <= 1'b0;
        edg(3);
        chk(dev, 1'b1, "dec");
        t0 = tbv;
        edg(3);
        chk(dev, 1'b1, "reload");
        chk(tbv, t0 + 64'h3, "time base");
        @(posedge clk);
        wk <= 1'b1;
        wie <= 1'b1;
        @(posedge clk);
        wk <= 1'b0;
        #5;
        chk(wirq, 1'b0, "kick");
        repeat (64)
        begin
            edg(1);
            n += int'(fev);
        end
        edg(1);
        chk(64'(n), 64'h4, "interval");
        chk(wirq, 1'b1, "watchdog");
    endtask

    initial
    begin
        for (int i = 0; i < 6; i++)
        begin
            radr[i] = 5'h0;
            if (i < 3)
                wadr[i] = 5'h0;
            if (i < 3)
                wdat[i] = 32'h0;
            if (i < 2)
                sc[i] = CL_INT;
            if (i < 2)
                sa[i] = 32'h0;
            if (i < 2)
                sb[i] = 32'h0;
        end
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_issue();
        t_arith();
        t_misc();
        t_miss_pred();
        t_timer();
        finish_test();
    end

    // the sequence needs some 170 cycles; over fourteen times that means a hang
    initial
    begin
        repeat (2500) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule // dual_issue_integer_core_pipeline_tb_top
